//--- hw/lcdcd_cfg.svh
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH
// command opcodes and field reset values
`define LCDCD_OP_CA_LO 4'h0
`define LCDCD_OP_CA_HI 4'h1
`define LCDCD_OP_MAP 4'hc
`define LCDCD_OP_GAIN 8'h81
`define LCDCD_OP_RAC 5'h11
`define LCDCD_RST_GAIN 2'h3
`define LCDCD_RST_POT 6'h00
`define LCDCD_RST_RAC 3'h1
`define LCDCD_RST_MAP 4'h0
`define LCDCD_RST_COL 8'h00
`define LCDCD_STATUS_ONE 0
`endif

//--- hw/lcdcd_pkg.sv
package lcdcd_pkg;
  // command byte sequencing state
  typedef enum logic [1:0] {
    LCDCD_IDLE = 2'b01,
    LCDCD_GAIN_ARG = 2'b10
  } lcdcd_state_t;
endpackage : lcdcd_pkg

//--- hw/lcdcd_top.sv
// Operation
// - command 0000xxxx loads column_address low nibble; resets to zero.
// - command 0001xxxx loads column_address high nibble, low nibble kept.
// - command 0x81 then next command byte sets gain_select and pot_value.
// - command 10001xxx loads ram_addr_ctrl; resets to 001.
// - command 1100xxxx loads display_map_ctrl; resets to zero.
`timescale 1ns/1ps
`include "lcdcd_cfg.svh"
module lcdcd_top
  import lcdcd_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // host strobes, one-cycle pulses from same-clock logic
  input wire logic CMD_OR_DATA_SEL,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] WDATA,
  // read answer
  output logic [7:0] RDATA,
  output logic RVALID,
  // display data path
  output logic [7:0] DISP_WDATA,
  output logic DISP_WE,
  input wire logic [7:0] DISP_RDATA,
  input wire logic [5:0] STATUS_FLAGS,
  // decoded fields
  output logic [7:0] COLUMN_ADDRESS,
  output logic [1:0] GAIN_SELECT,
  output logic [5:0] POT_VALUE,
  output logic [2:0] RAM_ADDR_CTRL,
  output logic [3:0] DISPLAY_MAP_CTRL
);
  lcdcd_state_t state_q;
  logic cmd_wr;
  logic [7:0] col_q;
  logic [1:0] gain_q;
  logic [5:0] pot_q;
  logic [2:0] rac_q;
  logic [3:0] map_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] dwdata_q;
  logic dwe_q;

  // upper-nibble opcode match, shared by the column and map loads and their checks
  function automatic logic nib_match(input logic [7:0] b, input logic [3:0] op);
    return b[7:4] == op;
  endfunction : nib_match

  // only command writes steer the decoder
  assign cmd_wr = WR_STB && !CMD_OR_DATA_SEL;

  // two-byte gain command sequencing
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= LCDCD_IDLE;
    end else if (cmd_wr) begin
      case (state_q)
        LCDCD_IDLE: state_q <= (WDATA == `LCDCD_OP_GAIN) ? LCDCD_GAIN_ARG : LCDCD_IDLE;
        LCDCD_GAIN_ARG: state_q <= LCDCD_IDLE;
        default: state_q <= LCDCD_IDLE;
      endcase
    end
  end

  // single-byte field loads; the gain argument byte is not decoded as a command
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      col_q <= `LCDCD_RST_COL;
      rac_q <= `LCDCD_RST_RAC;
      map_q <= `LCDCD_RST_MAP;
      gain_q <= `LCDCD_RST_GAIN;
      pot_q <= `LCDCD_RST_POT;
    end else if (cmd_wr) begin
      if (state_q == LCDCD_GAIN_ARG) begin
        gain_q <= WDATA[7:6];
        pot_q <= WDATA[5:0];
      end else if (nib_match(WDATA, `LCDCD_OP_CA_LO)) begin
        col_q[3:0] <= WDATA[3:0];
      end else if (nib_match(WDATA, `LCDCD_OP_CA_HI)) begin
        col_q[7:4] <= WDATA[3:0];
      end else if (WDATA[7:3] == `LCDCD_OP_RAC) begin
        rac_q <= WDATA[2:0];
      end else if (nib_match(WDATA, `LCDCD_OP_MAP)) begin
        map_q <= WDATA[3:0];
      end
    end
  end

  // data writes pass one byte to the display memory side
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dwe_q <= 1'b0;
      dwdata_q <= 8'h00;
    end else begin
      dwe_q <= WR_STB && CMD_OR_DATA_SEL;
      if (WR_STB && CMD_OR_DATA_SEL) begin
        dwdata_q <= WDATA;
      end
    end
  end

  // read answer one cycle after the strobe; status bit0 forced high
  // only five flag bits fit beside the gain pair, so the top flag is dropped
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      rvalid_q <= RD_STB;
      if (RD_STB) begin
        rdata_q <= CMD_OR_DATA_SEL ? DISP_RDATA : {STATUS_FLAGS[4:0], gain_q, 1'b1};
      end
    end
  end

  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;
  assign DISP_WDATA = dwdata_q;
  assign DISP_WE = dwe_q;
  assign COLUMN_ADDRESS = col_q;
  assign GAIN_SELECT = gain_q;
  assign POT_VALUE = pot_q;
  assign RAM_ADDR_CTRL = rac_q;
  assign DISPLAY_MAP_CTRL = map_q;

  // sequences for the two-byte gain command
  sequence s_gain_op;
    cmd_wr && state_q == LCDCD_IDLE && WDATA == `LCDCD_OP_GAIN;
  endsequence
  sequence s_gain_arg;
    cmd_wr && state_q == LCDCD_GAIN_ARG;
  endsequence

  property p_ca_lo;
    @(posedge CLK) disable iff (!ARST_N)
    cmd_wr && state_q == LCDCD_IDLE && nib_match(WDATA, `LCDCD_OP_CA_LO)
    |=> COLUMN_ADDRESS[3:0] == $past(WDATA[3:0]) && $stable(COLUMN_ADDRESS[7:4]);
  endproperty
  a_ca_lo: assert property (p_ca_lo) else $error("column low nibble not loaded");

  property p_ca_hi;
    @(posedge CLK) disable iff (!ARST_N)
    cmd_wr && state_q == LCDCD_IDLE && nib_match(WDATA, `LCDCD_OP_CA_HI)
    |=> COLUMN_ADDRESS[7:4] == $past(WDATA[3:0]) && $stable(COLUMN_ADDRESS[3:0]);
  endproperty
  a_ca_hi: assert property (p_ca_hi) else $error("column high nibble not loaded");

  // any other command, and the gain argument, leave the column alone
  property p_col_hold;
    @(posedge CLK) disable iff (!ARST_N)
    !(cmd_wr && state_q == LCDCD_IDLE && (nib_match(WDATA, `LCDCD_OP_CA_LO) ||
      nib_match(WDATA, `LCDCD_OP_CA_HI))) |=> $stable(COLUMN_ADDRESS);
  endproperty
  a_col_hold: assert property (p_col_hold) else $error("column changed unbidden");

  // the opcode byte arms the argument slot
  property p_gain_arm;
    @(posedge CLK) disable iff (!ARST_N)
    s_gain_op |=> state_q == LCDCD_GAIN_ARG;
  endproperty
  a_gain_arm: assert property (p_gain_arm) else $error("gain opcode not armed");

  // data transfers may sit between opcode and argument, so only the argument is checked
  property p_gain;
    @(posedge CLK) disable iff (!ARST_N)
    s_gain_arg |=> {GAIN_SELECT, POT_VALUE} == $past(WDATA);
  endproperty
  a_gain: assert property (p_gain) else $error("gain/pot not loaded");

  property p_gain_hold;
    @(posedge CLK) disable iff (!ARST_N)
    !(cmd_wr && state_q == LCDCD_GAIN_ARG) |=> $stable({GAIN_SELECT, POT_VALUE});
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed unbidden");

  property p_rac;
    @(posedge CLK) disable iff (!ARST_N)
    cmd_wr && state_q == LCDCD_IDLE && WDATA[7:3] == `LCDCD_OP_RAC
    |=> RAM_ADDR_CTRL == $past(WDATA[2:0]);
  endproperty
  a_rac: assert property (p_rac) else $error("ram address control not loaded");

  property p_map;
    @(posedge CLK) disable iff (!ARST_N)
    cmd_wr && state_q == LCDCD_IDLE && nib_match(WDATA, `LCDCD_OP_MAP)
    |=> DISPLAY_MAP_CTRL == $past(WDATA[3:0]);
  endproperty
  a_map: assert property (p_map) else $error("mapping control not loaded");

  property p_status;
    @(posedge CLK) disable iff (!ARST_N)
    RD_STB && !CMD_OR_DATA_SEL |=> RVALID && RDATA[`LCDCD_STATUS_ONE] &&
      RDATA[7:1] == {$past(STATUS_FLAGS[4:0]), $past(GAIN_SELECT)};
  endproperty
  a_status: assert property (p_status) else $error("status bit0 not one");

  property p_dwrite;
    @(posedge CLK) disable iff (!ARST_N)
    WR_STB && CMD_OR_DATA_SEL |=> DISP_WE && DISP_WDATA == $past(WDATA);
  endproperty
  a_dwrite: assert property (p_dwrite) else $error("data write lost");

  property p_dread;
    @(posedge CLK) disable iff (!ARST_N)
    RD_STB && CMD_OR_DATA_SEL |=> RVALID && RDATA == $past(DISP_RDATA);
  endproperty
  a_dread: assert property (p_dread) else $error("data read wrong");

  // answer and write strobes are single-cycle pulses
  property p_rvalid_pulse;
    @(posedge CLK) disable iff (!ARST_N)
    !RD_STB |=> !RVALID;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer stuck");

  property p_dwe_pulse;
    @(posedge CLK) disable iff (!ARST_N)
    !(WR_STB && CMD_OR_DATA_SEL) |=> !DISP_WE;
  endproperty
  a_dwe_pulse: assert property (p_dwe_pulse) else $error("data write strobe stuck");
endmodule : lcdcd_top

//--- tb/lcdcd_host.sv
`timescale 1ns/1ps
module lcdcd_host (
  // clock
  input wire logic clk,
  // host bus toward the decoder
  output logic sel,
  output logic wr,
  output logic rd,
  output logic [7:0] wd
);
  // idle bus at time zero
  initial begin
    sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wd = 8'h00;
  end
  // one strobe cycle; callers also pass unlisted bytes such as 8'he3 and the data byte 8'h33
  task automatic xfer(input logic s, input logic w, input logic [7:0] d);
    @(posedge clk);
    #1;
    sel = s;
    wr = w;
    rd = !w;
    wd = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    wd = ~d; // stale byte must not look valid
  endtask : xfer
endmodule : lcdcd_host

//--- tb/test_lcdcd_top.sv
`timescale 1ns/1ps
module test_lcdcd_top;
  logic clk, arst_n, sel, wr, rd, rvalid, dwe;
  logic [7:0] wd, rdata, dwd, drd, col;
  logic [5:0] sflags, pot;
  logic [1:0] gain;
  logic [2:0] rac;
  logic [3:0] map;
  int err_total = 0;
  int num_checks = 0;
  lcdcd_host u_host (.clk(clk), .sel(sel), .wr(wr), .rd(rd), .wd(wd));
  lcdcd_top u_dut (.CLK(clk), .ARST_N(arst_n), .CMD_OR_DATA_SEL(sel), .WR_STB(wr),
    .RD_STB(rd), .WDATA(wd), .RDATA(rdata), .RVALID(rvalid), .DISP_WDATA(dwd),
    .DISP_WE(dwe), .DISP_RDATA(drd), .STATUS_FLAGS(sflags), .COLUMN_ADDRESS(col),
    .GAIN_SELECT(gain), .POT_VALUE(pot), .RAM_ADDR_CTRL(rac), .DISPLAY_MAP_CTRL(map));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // byte compare; narrow fields are zero-extended
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic t_reset();
    chk8("col", 8'h00, col);
    chk8("gain", 8'h03, {6'h00, gain});
    chk8("pot", 8'h00, {2'h0, pot});
    chk8("rac", 8'h01, {5'h00, rac});
    chk8("map", 8'h00, {4'h0, map});
    u_host.xfer(1'b0, 1'b0, 8'h00);
    chk8("status", {sflags[4:0], 2'h3, 1'b1}, rdata);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_cmd();
    u_host.xfer(1'b0, 1'b1, 8'h05);
    chk8("col", 8'h05, col);
    u_host.xfer(1'b0, 1'b1, 8'h1a);
    chk8("col", 8'ha5, col);
    u_host.xfer(1'b0, 1'b1, 8'h8e);
    chk8("rac", 8'h06, {5'h00, rac});
    u_host.xfer(1'b0, 1'b1, 8'hc9);
    chk8("map", 8'h09, {4'h0, map});
    u_host.xfer(1'b0, 1'b1, 8'he3);
    chk8("col", 8'ha5, col);
    chk8("map", 8'h09, {4'h0, map});
    $display("t_cmd done");
  endtask : t_cmd
  // argument byte looks like a column command and must not act as one
  task automatic t_gain();
    u_host.xfer(1'b0, 1'b1, 8'h81);
    u_host.xfer(1'b1, 1'b1, 8'h33);
    chk8("gain", 8'h03, {6'h00, gain});
    u_host.xfer(1'b0, 1'b1, 8'h0c);
    chk8("gainpot", 8'h0c, {gain, pot});
    chk8("col", 8'ha5, col);
    $display("t_gain done");
  endtask : t_gain
  task automatic t_data();
    u_host.xfer(1'b1, 1'b1, 8'ha7);
    chk8("dwe", 8'h01, {7'h00, dwe});
    chk8("dwd", 8'ha7, dwd);
    @(posedge clk);
    #1;
    chk8("dwe", 8'h00, {7'h00, dwe});
    chk8("dwd", 8'ha7, dwd);
    u_host.xfer(1'b1, 1'b0, 8'h00);
    chk8("rvalid", 8'h01, {7'h00, rvalid});
    chk8("rdata", 8'h5c, rdata);
    @(posedge clk);
    #1;
    chk8("rvalid", 8'h00, {7'h00, rvalid});
    chk8("rdata", 8'h5c, rdata);
    u_host.xfer(1'b0, 1'b0, 8'h00);
    chk8("status", {sflags[4:0], 2'h0, 1'b1}, rdata);
    $display("t_data done");
  endtask : t_data
  // mid-run reset returns every field to its default at once
  task automatic t_rerst();
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    #1;
    chk8("col", 8'h00, col);
    chk8("gain", 8'h03, {6'h00, gain});
    chk8("pot", 8'h00, {2'h0, pot});
    chk8("rac", 8'h01, {5'h00, rac});
    chk8("map", 8'h00, {4'h0, map});
    chk8("rvalid", 8'h00, {7'h00, rvalid});
    @(posedge clk);
    #1;
    arst_n = 1'b1;
    u_host.xfer(1'b0, 1'b1, 8'h13);
    chk8("col", 8'h30, col);
    $display("t_rerst done");
  endtask : t_rerst
  // watchdog against a hang
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  // reset, then the scenarios
  initial begin
    arst_n = 1'b0;
    drd = 8'h5c;
    sflags = 6'h15;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_cmd();
    t_gain();
    t_data();
    t_rerst();
    print_verdict();
  end
endmodule : test_lcdcd_top
